// ---- hdl/cmsr_bank.sv ----
// Clock monitor configuration and output skew register bank
// How it works
// - Absence mode high bits in 0x8a[3:0], low bits in 0x8b[7:4].
// - Mode 00 off, 01 reserved, 10 slow detector, 11 normal detector.
// - Slow detector needs a longer quiet run than normal one.
// - One frequency offset enable per input in 0x8b[3:0], 1 enables.
// - Reset loads 0x8b with all ones, all offset monitors enabled.
// - Each output skew is an 8-bit signed offset in divider clocks.
// - Reset sets output two skew to one divider clock.
// - Reset sets output three skew to zero.
`timescale 1ns/1ps

module cmsr_bank
  import cmsr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire cmsr_req_t i_cfg_req,
  input wire logic [3:0] i_clk_activity,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [3:0][1:0] o_absence_mode,
  output logic [3:0] o_freq_offset_enable,
  output logic [3:0] o_input_absence,
  output logic signed [3:0][7:0] o_phase_offset
);

  //////////////////////////////////////////////////////////////////////////
  // Bank state, kept as one record
  typedef struct packed {
    logic [3:0] mode_hi;
    logic [7:0] low_fos;
    logic [3:0][7:0] skew;
    logic [7:0] rd_data;
    logic rd_valid;
  } cmsr_bank_t;

  cmsr_bank_t s_q;
  cmsr_bank_t s_d;

  //////////////////////////////////////////////////////////////////////////
  // Register writes and read-back
  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    // Writes land on the edge that takes them
    if (i_cfg_req.wr_en) begin
      case (i_cfg_req.addr)
        ADDR_MODE_HI: begin
          // Upper nibble dropped: it holds nothing
          s_d.mode_hi = i_cfg_req.wdata[3:0];
        end
        ADDR_LOW_FOS: begin
          s_d.low_fos = i_cfg_req.wdata;
        end
        ADDR_SKEW1: begin
          s_d.skew[0] = i_cfg_req.wdata;
        end
        ADDR_SKEW2: begin
          s_d.skew[1] = i_cfg_req.wdata;
        end
        ADDR_SKEW3: begin
          s_d.skew[2] = i_cfg_req.wdata;
        end
        ADDR_SKEW4: begin
          s_d.skew[3] = i_cfg_req.wdata;
        end
        default: begin
          s_d.mode_hi = s_q.mode_hi;
        end
      endcase
    end
    // A read in the same cycle as a write returns the old value
    if (i_cfg_req.rd_en) begin
      s_d.rd_valid = 1'b1;
      case (i_cfg_req.addr)
        ADDR_MODE_HI: begin
          s_d.rd_data = {4'h0, s_q.mode_hi};
        end
        ADDR_LOW_FOS: begin
          s_d.rd_data = s_q.low_fos;
        end
        ADDR_SKEW1: begin
          s_d.rd_data = s_q.skew[0];
        end
        ADDR_SKEW2: begin
          s_d.rd_data = s_q.skew[1];
        end
        ADDR_SKEW3: begin
          s_d.rd_data = s_q.skew[2];
        end
        ADDR_SKEW4: begin
          s_d.rd_data = s_q.skew[3];
        end
        default: begin
          // Unmapped addresses read as zero
          s_d.rd_data = 8'h00;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register with its reset values
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q.mode_hi <= RST_MODE_HI;
      s_q.low_fos <= RST_LOW_FOS;
      s_q.skew[0] <= RST_SKEW1;
      s_q.skew[1] <= RST_SKEW2;
      s_q.skew[2] <= RST_SKEW3;
      s_q.skew[3] <= RST_SKEW4;
      s_q.rd_data <= RST_RD_DATA;
      s_q.rd_valid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port outputs
  assign o_rd_data = s_q.rd_data;
  assign o_rd_valid = s_q.rd_valid;

  //////////////////////////////////////////////////////////////////////////
  // Per-input fields and detectors
  // Mode bits are split across two registers, so each half takes effect
  // on its own write and the mode is whole only once both writes have landed.
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
    assign o_absence_mode[i] = {s_q.mode_hi[MODE_HI_LSB + i],
                                s_q.low_fos[MODE_LO_LSB + i]};
    assign o_freq_offset_enable[i] = s_q.low_fos[FOS_EN_LSB + i];

    // Reserved code 01 arms nothing, same as off
    cmsr_absence_det u_det (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_mode(o_absence_mode[i]),
      .i_activity(i_clk_activity[i]),
      .o_absent(o_input_absence[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Skew fields handed to the phase datapath as signed values
  for (genvar k = 0; k < NUM_OUTPUTS; k++) begin : g_out
    assign o_phase_offset[k] = s_q.skew[k];
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence wr_to(logic [7:0] a);
    i_cfg_req.wr_en && i_cfg_req.addr == a;
  endsequence

  sequence rd_to(logic [7:0] a);
    i_cfg_req.rd_en && !i_cfg_req.wr_en && i_cfg_req.addr == a;
  endsequence

  // Offset monitors come out of reset enabled; absence modes reset to reserved 01
  fos_reset_a: assert property (
    @(posedge i_clk_sys)
    $rose(i_resetn) |-> o_freq_offset_enable == 4'hf
      && o_absence_mode[0][0] && o_absence_mode[3][0])
    else $error("offset enables not all set after reset");

  skew2_reset_a: assert property (
    @(posedge i_clk_sys)
    $rose(i_resetn) |-> o_phase_offset[1] == 8'sh01)
    else $error("output two skew reset wrong");

  skew3_reset_a: assert property (
    @(posedge i_clk_sys)
    $rose(i_resetn) |-> o_phase_offset[2] == 8'sh00)
    else $error("output three skew reset wrong");

  // High mode bits follow the low nibble of the write
  mode_hi_write_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    wr_to(ADDR_MODE_HI) |=>
      o_absence_mode[0][1] == $past(i_cfg_req.wdata[0])
      && o_absence_mode[3][1] == $past(i_cfg_req.wdata[3]))
    else $error("high mode bit not stored");

  // Reserved nibble reads back zero even after writing ones
  rsvd_read_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    rd_to(ADDR_MODE_HI) |=> o_rd_valid && o_rd_data[7:4] == 4'h0
      && o_rd_data[3:0] == {o_absence_mode[3][1], o_absence_mode[2][1],
                            o_absence_mode[1][1], o_absence_mode[0][1]})
    else $error("reserved mode bits not zero");

  fos_write_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    wr_to(ADDR_LOW_FOS) |=>
      o_freq_offset_enable == $past(i_cfg_req.wdata[3:0])
      && o_absence_mode[2][0] == $past(i_cfg_req.wdata[6]))
    else $error("offset enables not stored");

  // Written skew reads back the same signed value two cycles on
  skew_write_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    wr_to(ADDR_SKEW4) ##1 rd_to(ADDR_SKEW4) |=>
      o_rd_data == $past(i_cfg_req.wdata, 2)
      && o_phase_offset[3] == $past(i_cfg_req.wdata, 2))
    else $error("output four skew not stored");

  // Off mode never raises an absence alarm
  off_quiet_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    (o_absence_mode[0] == MODE_OFF) [*2] |-> !o_input_absence[0])
    else $error("absence raised while monitoring off");

endmodule

// ---- hdl/cmsr_pkg.sv ----
// Shared constants and carrier types for the clock monitor and skew bank
package cmsr_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets on the configuration port
  localparam logic [7:0] ADDR_MODE_HI = 8'h8a;
  localparam logic [7:0] ADDR_LOW_FOS = 8'h8b;
  localparam logic [7:0] ADDR_SKEW1 = 8'h8c;
  localparam logic [7:0] ADDR_SKEW2 = 8'h8d;
  localparam logic [7:0] ADDR_SKEW3 = 8'h8e;
  localparam logic [7:0] ADDR_SKEW4 = 8'h8f;

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int MODE_HI_LSB = 0;
  localparam int MODE_LO_LSB = 4;
  localparam int FOS_EN_LSB = 0;
  localparam int NUM_INPUTS = 4;
  localparam int NUM_OUTPUTS = 4;

  //////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [3:0] RST_MODE_HI = 4'h0;
  localparam logic [7:0] RST_LOW_FOS = 8'hff;
  localparam logic [7:0] RST_SKEW1 = 8'h00;
  localparam logic [7:0] RST_SKEW2 = 8'h01;
  localparam logic [7:0] RST_SKEW3 = 8'h00;
  localparam logic [7:0] RST_SKEW4 = 8'h00;
  localparam logic [7:0] RST_RD_DATA = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Absence detection modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RSVD = 2'h1;
  localparam logic [1:0] MODE_SLOW = 2'h2;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  //////////////////////////////////////////////////////////////////////////
  // Detector timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int NORM_ABS_NS = 400;
  localparam int SLOW_ABS_NS = 1600;
  localparam logic [7:0] NORM_ABS_CYC = 8'(NORM_ABS_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SLOW_ABS_CYC = 8'(SLOW_ABS_NS / CLK_PERIOD_NS);

  //////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cmsr_req_t;

  typedef enum logic [1:0] {
    DET_IDLE,
    DET_WATCH,
    DET_ABSENT
  } cmsr_det_state_t;

endpackage

// ---- hdl/cmsr_absence_det.sv ----
// Per-input absence detector with normal and slow variants
`timescale 1ns/1ps

module cmsr_absence_det
  import cmsr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic [1:0] i_mode,
  input wire logic i_activity,
  output logic o_absent
);

  typedef struct packed {
    cmsr_det_state_t st;
    logic [1:0] mode;
    logic [7:0] quiet;
    logic absent;
  } cmsr_det_t;

  cmsr_det_t s_q;
  cmsr_det_t s_d;
  logic [7:0] limit;
  logic armed;

  ////////////////////////////////////////////////////////////////////////
  // Slow variant waits longer, so short gaps never raise it
  assign limit = (i_mode == MODE_SLOW) ? SLOW_ABS_CYC : NORM_ABS_CYC;
  assign armed = (i_mode == MODE_SLOW) || (i_mode == MODE_NORMAL);

  // Next state; a mode change restarts the watch from scratch
  always_comb begin
    s_d = s_q;
    s_d.mode = i_mode;
    case (s_q.st)
      DET_IDLE: begin
        s_d.quiet = 8'h00;
        s_d.absent = 1'b0;
        if (armed) begin
          s_d.st = DET_WATCH;
        end
      end
      DET_WATCH: begin
        if (!armed || i_mode != s_q.mode) begin
          s_d.st = DET_IDLE;
          s_d.quiet = 8'h00;
        end else if (i_activity) begin
          s_d.quiet = 8'h00;
        end else if (s_q.quiet == limit - 8'h01) begin
          s_d.absent = 1'b1;
          s_d.st = DET_ABSENT;
        end else begin
          s_d.quiet = s_q.quiet + 8'h01;
        end
      end
      DET_ABSENT: begin
        if (!armed || i_mode != s_q.mode) begin
          s_d.st = DET_IDLE;
          s_d.absent = 1'b0;
        end else if (i_activity) begin
          s_d.absent = 1'b0;
          s_d.quiet = 8'h00;
          s_d.st = DET_WATCH;
        end
      end
      default: begin
        s_d.st = DET_IDLE;
        s_d.absent = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '{st: DET_IDLE, mode: MODE_OFF, quiet: 8'h00, absent: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_absent = s_q.absent;

  ////////////////////////////////////////////////////////////////////////
  // Alarm only after a full quiet run of the selected length
  slow_thresh_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_resetn)
    $rose(o_absent) |-> $past(s_q.quiet) == $past(limit) - 8'h01)
    else $error("absence raised before quiet run ended");

endmodule

// ---- dv/cmsr_tb.sv ----
// Self-checking bench for the clock monitor and skew register bank
`timescale 1ns/1ps

module testbench
  import cmsr_pkg::*;
;
  logic i_clk_sys;
  logic i_resetn;
  cmsr_req_t req;
  logic [3:0] act;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [3:0][1:0] mode;
  logic [3:0] frequency_offset_detect;
  logic [3:0] absn;
  logic signed [3:0][7:0] skew;
  int mismatches;
  int tests_run;

  cmsr_bank u_dut (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_cfg_req(req),
    .i_clk_activity(act),
    .o_rd_data(rd_data),
    .o_rd_valid(rd_valid),
    .o_absence_mode(mode),
    .o_freq_offset_enable(frequency_offset_detect),
    .o_input_absence(absn),
    .o_phase_offset(skew)
  );

  //////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared compare, verdict and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Strobe stays up between calls so back-to-back writes need no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = cmsr_req_t'({1'b1, 1'b0, a, d});
    @(negedge i_clk_sys);
  endtask

  task automatic idle();
    req = '0;
    @(negedge i_clk_sys);
  endtask

  // Valid pulse and data stand in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req = cmsr_req_t'({1'b0, 1'b1, a, 8'h00});
    @(negedge i_clk_sys);
    chk({31'h0, rd_valid}, 32'h1);
    chk({24'h0, rd_data}, {24'h0, exp});
    req = '0;
    @(negedge i_clk_sys);
    // Valid lasts one cycle only
    chk({31'h0, rd_valid}, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({24'h0, mode}, 32'h55);
    chk({28'h0, frequency_offset_detect}, 32'hf);
    chk(skew, 32'h00000100);
    chk({28'h0, absn}, 32'h0);
    rd(ADDR_MODE_HI, 8'h00);
    rd(ADDR_LOW_FOS, 8'hff);
    rd(ADDR_SKEW2, 8'h01);
    rd(ADDR_SKEW3, 8'h00);
  endtask

  task automatic t_fields();
    wr(ADDR_MODE_HI, 8'hf5);
    wr(ADDR_LOW_FOS, 8'h3a);
    wr(ADDR_SKEW1, 8'h80);
    wr(ADDR_SKEW2, 8'h7f);
    wr(ADDR_SKEW3, 8'hff);
    wr(ADDR_SKEW4, 8'h01);
    wr(8'h90, 8'h55);
    idle();
    // Modes pair 0x8a[n] with 0x8b[n+4]: inputs 11, 01, 10, 00
    chk({24'h0, mode}, 32'h27);
    chk({28'h0, frequency_offset_detect}, 32'ha);
    chk(skew, 32'h01ff7f80);
    // Element selects are unsigned, so the sign is restored first
    chk({31'h0, $signed(skew[0]) < 0}, 32'h1);
    chk({31'h0, $signed(skew[2]) == -1}, 32'h1);
    rd(ADDR_MODE_HI, 8'h05);
    rd(ADDR_LOW_FOS, 8'h3a);
    rd(ADDR_SKEW1, 8'h80);
    rd(ADDR_SKEW4, 8'h01);
    rd(8'h90, 8'h00);
    rd(8'h89, 8'h00);
    // Write then read on the very next edge
    wr(ADDR_SKEW4, 8'hc3);
    rd(ADDR_SKEW4, 8'hc3);
  endtask

  // Quiet input 1 until its alarm; count must sit in the given window
  task automatic quiet(input int lo, input int hi);
    int n;
    n = 0;
    act[0] = 1'b0;
    while (absn[0] !== 1'b1 && n < 100) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
    act[0] = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk({31'h0, absn[0]}, 32'h0);
  endtask

  task automatic t_detect();
    // Normal mode on input 1, others off
    wr(ADDR_MODE_HI, 8'h01);
    wr(ADDR_LOW_FOS, 8'h10);
    idle();
    repeat (3) @(negedge i_clk_sys);
    quiet(9, 13);
    // Slow mode must take clearly longer than normal
    wr(ADDR_LOW_FOS, 8'h00);
    idle();
    repeat (3) @(negedge i_clk_sys);
    quiet(38, 43);
    // All inputs normal; only the quiet lines 2 and 4 may alarm
    wr(ADDR_MODE_HI, 8'h0f);
    wr(ADDR_LOW_FOS, 8'hf0);
    idle();
    repeat (3) @(negedge i_clk_sys);
    act = 4'h5;
    repeat (12) @(negedge i_clk_sys);
    chk({28'h0, absn}, 32'ha);
    act = 4'hf;
    repeat (2) @(negedge i_clk_sys);
    chk({28'h0, absn}, 32'h0);
    // Off and reserved modes never alarm, even with all inputs quiet
    wr(ADDR_MODE_HI, 8'h00);
    wr(ADDR_LOW_FOS, 8'hf0);
    idle();
    act = 4'h0;
    repeat (60) @(negedge i_clk_sys);
    chk({28'h0, absn}, 32'h0);
    wr(ADDR_LOW_FOS, 8'h00);
    idle();
    repeat (60) @(negedge i_clk_sys);
    chk({28'h0, absn}, 32'h0);
    act = 4'hf;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset held for 4 cycles, released off the sampling edge
  initial begin
    mismatches = 0;
    tests_run = 0;
    i_resetn = 1'b0;
    req = '0;
    act = 4'hf;
    repeat (4) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    @(negedge i_clk_sys);
    t_reset();
    t_fields();
    t_detect();
    finish_test();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #200us;
    mismatches++;
    finish_test();
  end

endmodule
